/* rtl/blink_timer.sv */
// Shared flash timer: square wave with a fixed half period.
// Assumes one free-running clock; every flashing lamp uses this phase.
`default_nettype none

module blink_timer #(
  parameter int HALF_CYCLES = nav_io_pkg::BLINK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Flash phase
  output logic phase
);

  localparam int CW = $clog2(HALF_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic phase;
  } blink_t;

  blink_t st;
  blink_t next_st;

  always_comb
  begin
    next_st = st;
    if (st.cnt == CW'(HALF_CYCLES - 1))
    begin
      // Equal halves give the 50 percent duty
      next_st.cnt = '0;
      next_st.phase = ~st.phase;
    end
    else
    begin
      next_st.cnt = st.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '{cnt: '0, phase: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign phase = st.phase;

endmodule : blink_timer

`default_nettype wire

/* rtl/nav_discrete_annunciator_io.sv */
// Navigation discrete I/O: lamps, guidance discretes, switches, time mark.
// Assumes a 40 MHz clock, an AHB-Lite master for navigation state, and
// external sinking drivers resolved from DISC_OE.
//
// Function
// - Message lamp flashes on a new message, steady while messages remain.
// - Waypoint lamp flashes within 10 s of a course-change turn point.
// - Waypoint lamp steady during a turn until it completes.
// - With arrival alarm set, entering alarm radius flashes waypoint lamp 10 s.
// - Without arrival alarm, waypoint lamp flashes within 10 s of arrival.
// - Source toggle low swaps satellite and VOR/localizer source like the key.
// - Single indicator: VOR/localizer lamp lit while that data is shown.
// - Single indicator: satellite lamp lit while satellite data is shown.
// - Course-hold toggle low swaps course-hold and automatic sequencing.
// - Course-hold lamp lit with course-hold or sequencing-suspended shown.
// - Terminal lamp: approach navigation, within 30 nm, scale 1.0 nm or less.
// - Approach lamp lit during approach navigation with approach active.
// - Integrity lamp lit on position error or unknown integrity.
// - Approach gain: satellite with approach or 0.3 nmi, or VOR with ILS.
// - Simulation strap sampled once at power-up; low selects simulation.
// - Guidance select low only with satellite data shown and gain inactive.
// - Second mark 1 ms wide every 1.0 s, timed from satellite reference.
// - Each preset step low loads next preset into standby frequency.
// - Switch inputs asserted near ground, deasserted at supply level.
// - Lamp and discrete outputs are active-low sinking drivers.
`default_nettype none

module nav_discrete_annunciator_io #(
  parameter int DEBOUNCE_CYCLES = nav_io_pkg::DEBOUNCE_CYCLES,
  parameter int BLINK_HALF_CYCLES = nav_io_pkg::BLINK_HALF_CYCLES,
  parameter int SECOND_CYCLES = nav_io_pkg::SECOND_CYCLES,
  parameter int MARK_CYCLES = nav_io_pkg::MARK_CYCLES,
  parameter int ALARM_CYCLES = nav_io_pkg::ALARM_CYCLES,
  parameter int NUM_PRESETS = nav_io_pkg::NUM_PRESETS
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Switch pins, low when grounded
  input wire logic NAV_SOURCE_TOGGLE_IN_N,
  input wire logic COURSE_HOLD_TOGGLE_IN_N,
  input wire logic PRESET_STEP_IN_N,
  input wire logic SIM_STRAP_IN_N,
  // Satellite time reference pin
  input wire logic TIME_REF_IN,
  // Sinking discrete outputs
  output logic [nav_io_pkg::NUM_OUT-1:0] DISC_OUT_N,
  output logic [nav_io_pkg::NUM_OUT-1:0] DISC_OE,
  // Logic-level second mark
  output logic TIME_MARK_OUT
);

  localparam int IW = (NUM_PRESETS > 1) ? $clog2(NUM_PRESETS) : 1;
  localparam int SW = $clog2(SECOND_CYCLES + 1);
  localparam int MW = $clog2(MARK_CYCLES + 1);
  localparam int AW = $clog2(ALARM_CYCLES + 1);
  localparam int FW = nav_io_pkg::FREQ_W;
  localparam int NO = nav_io_pkg::NUM_OUT;

  typedef struct packed {
    logic wr_pend;
    logic [7:0] waddr;
    logic [31:0] hrdata;
    logic [nav_io_pkg::NAV_W-1:0] nav;
    logic [NUM_PRESETS-1:0][FW-1:0] preset;
    logic [IW-1:0] preset_idx;
    logic [FW-1:0] standby;
    logic source_vloc;
    logic course_hold;
    logic sim_mode;
    logic strap_taken;
    logic msg_flash;
    logic radius_q;
    logic [AW-1:0] alarm_cnt;
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic [SW-1:0] sec_cnt;
    logic [MW-1:0] mark_cnt;
    logic mark;
    logic [NO-1:0] oe;
  } io_t;

  io_t st;
  io_t next_st;

  logic [nav_io_pkg::NUM_SW-1:0] sw_pin_n;
  logic [nav_io_pkg::NUM_SW-1:0] sw_level_n;
  logic [nav_io_pkg::NUM_SW-1:0] sw_fall;
  logic [nav_io_pkg::NUM_SW-1:0] sw_ready;
  logic blink;

  assign sw_pin_n[nav_io_pkg::SW_SOURCE] = NAV_SOURCE_TOGGLE_IN_N;
  assign sw_pin_n[nav_io_pkg::SW_COURSE_HOLD] = COURSE_HOLD_TOGGLE_IN_N;
  assign sw_pin_n[nav_io_pkg::SW_PRESET] = PRESET_STEP_IN_N;
  assign sw_pin_n[nav_io_pkg::SW_STRAP] = SIM_STRAP_IN_N;

  genvar gi;
  generate
    for (gi = 0; gi < nav_io_pkg::NUM_SW; gi++)
    begin : g_sw
      switch_debounce #(
        .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
      ) u_deb (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .pin_n(sw_pin_n[gi]),
        .level_n(sw_level_n[gi]),
        .fall(sw_fall[gi]),
        .ready(sw_ready[gi])
      );
    end
  endgenerate

  blink_timer #(
    .HALF_CYCLES(BLINK_HALF_CYCLES)
  ) u_blink (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .phase(blink)
  );

  always_comb
  begin
    logic [31:0] rd;
    logic [3:0] ev;
    logic wpt_flash;
    logic gain;
    logic ref_rise;
    logic start_mark;
    logic [7:0] rel;
    next_st = st;
    rd = 32'h0000_0000;
    ev = 4'h0;
    rel = 8'h00;
    wpt_flash = 1'b0;
    gain = 1'b0;
    ref_rise = 1'b0;
    start_mark = 1'b0;

    // Read data is captured at the address phase
    if (HADDR[7:0] == nav_io_pkg::REG_NAV_STATE)
    begin
      rd[nav_io_pkg::NAV_W-1:0] = st.nav;
    end
    else if (HADDR[7:0] == nav_io_pkg::REG_STATUS)
    begin
      rd[nav_io_pkg::ST_SOURCE_VLOC] = st.source_vloc;
      rd[nav_io_pkg::ST_COURSE_HOLD] = st.course_hold;
      rd[nav_io_pkg::ST_SIM_MODE] = st.sim_mode;
      rd[nav_io_pkg::ST_MSG_FLASH] = st.msg_flash;
      rd[nav_io_pkg::ST_ALARM_FLASH] = (st.alarm_cnt != '0);
      rd[nav_io_pkg::ST_TIME_MARK] = st.mark;
      rd[nav_io_pkg::ST_IDX_LSB +: IW] = st.preset_idx;
      rd[nav_io_pkg::ST_OE_LSB +: NO] = st.oe;
    end
    else if (HADDR[7:0] == nav_io_pkg::REG_STANDBY)
    begin
      rd[FW-1:0] = st.standby;
    end
    else
    begin
      for (int i = 0; i < NUM_PRESETS; i++)
      begin
        if (HADDR[7:0] == nav_io_pkg::REG_PRESET_BASE + 8'(4 * i))
        begin
          rd[FW-1:0] = st.preset[i];
        end
      end
    end
    if (HSEL && HREADY && HTRANS[1])
    begin
      next_st.wr_pend = HWRITE && (HSIZE == 3'b010);
      next_st.waddr = HADDR[7:0];
      next_st.hrdata = HWRITE ? 32'h0000_0000 : rd;
    end
    else
    begin
      next_st.wr_pend = 1'b0;
    end

    // Data phase write
    if (st.wr_pend)
    begin
      if (st.waddr == nav_io_pkg::REG_NAV_STATE)
      begin
        next_st.nav = HWDATA[nav_io_pkg::NAV_W-1:0];
      end
      else if (st.waddr == nav_io_pkg::REG_EVENT)
      begin
        ev = HWDATA[3:0];
      end
      rel = st.waddr - nav_io_pkg::REG_PRESET_BASE;
      for (int i = 0; i < NUM_PRESETS; i++)
      begin
        if (rel == 8'(4 * i))
        begin
          next_st.preset[i] = HWDATA[FW-1:0];
        end
      end
    end

    // Pin and front-panel key act alike
    if (sw_fall[nav_io_pkg::SW_SOURCE] || ev[nav_io_pkg::EV_KEY_SOURCE])
    begin
      next_st.source_vloc = ~st.source_vloc;
    end
    if (sw_fall[nav_io_pkg::SW_COURSE_HOLD] || ev[nav_io_pkg::EV_KEY_COURSE_HOLD])
    begin
      next_st.course_hold = ~st.course_hold;
    end
    if (sw_fall[nav_io_pkg::SW_PRESET])
    begin
      next_st.standby = st.preset[st.preset_idx];
      next_st.preset_idx = (st.preset_idx == IW'(NUM_PRESETS - 1)) ? '0 : st.preset_idx + IW'(1);
    end
    // Strap is taken once, after its first settled reading
    if (!st.strap_taken && sw_ready[nav_io_pkg::SW_STRAP])
    begin
      next_st.strap_taken = 1'b1;
      next_st.sim_mode = ~sw_level_n[nav_io_pkg::SW_STRAP];
    end

    // Flash until acknowledged or no message is active; a new message beats a same-cycle clear
    if (ev[nav_io_pkg::EV_MSG_ACK] || !st.nav[nav_io_pkg::NAV_MSG_ACTIVE])
    begin
      next_st.msg_flash = 1'b0;
    end
    if (ev[nav_io_pkg::EV_MSG_NEW])
    begin
      next_st.msg_flash = 1'b1;
    end

    // Arrival alarm: one 10 s flash per radius entry
    next_st.radius_q = st.nav[nav_io_pkg::NAV_IN_ALARM_RADIUS];
    if (st.nav[nav_io_pkg::NAV_ALARM_SET] && st.nav[nav_io_pkg::NAV_IN_ALARM_RADIUS] && !st.radius_q)
    begin
      next_st.alarm_cnt = AW'(ALARM_CYCLES);
    end
    else if (st.alarm_cnt != '0)
    begin
      next_st.alarm_cnt = st.alarm_cnt - AW'(1);
    end

    // Second mark: free-running, pulled into step by each rising reference edge
    next_st.ref_s1 = TIME_REF_IN;
    next_st.ref_s2 = st.ref_s1;
    next_st.ref_s3 = st.ref_s2;
    ref_rise = st.ref_s2 && !st.ref_s3;
    if (ref_rise || st.sec_cnt == SW'(SECOND_CYCLES - 1))
    begin
      next_st.sec_cnt = '0;
      start_mark = 1'b1;
    end
    else
    begin
      next_st.sec_cnt = st.sec_cnt + SW'(1);
    end
    // A start during a pulse is dropped so the width stays exact
    if (st.mark)
    begin
      if (st.mark_cnt == '0)
      begin
        next_st.mark = 1'b0;
      end
      else
      begin
        next_st.mark_cnt = st.mark_cnt - MW'(1);
      end
    end
    else if (start_mark)
    begin
      next_st.mark = 1'b1;
      next_st.mark_cnt = MW'(MARK_CYCLES - 1);
    end

    // Lamp and discrete decode
    wpt_flash = st.nav[nav_io_pkg::NAV_TURN_PENDING]
      || (st.alarm_cnt != '0)
      || (!st.nav[nav_io_pkg::NAV_ALARM_SET] && st.nav[nav_io_pkg::NAV_NEAR_ARRIVAL]);
    gain = (!st.source_vloc && (st.nav[nav_io_pkg::NAV_SATNAV_APPR_MODE] || st.nav[nav_io_pkg::NAV_SCALE_0P3]))
      || (st.source_vloc && st.nav[nav_io_pkg::NAV_ILS_TUNED]);
    next_st.oe[nav_io_pkg::OUT_MSG] = st.msg_flash ? blink : st.nav[nav_io_pkg::NAV_MSG_ACTIVE];
    next_st.oe[nav_io_pkg::OUT_WAYPOINT] = st.nav[nav_io_pkg::NAV_IN_TURN] || (wpt_flash && blink);
    next_st.oe[nav_io_pkg::OUT_VOR_LOC] = st.nav[nav_io_pkg::NAV_SINGLE_INDICATOR] && st.source_vloc;
    next_st.oe[nav_io_pkg::OUT_SATNAV] = st.nav[nav_io_pkg::NAV_SINGLE_INDICATOR] && !st.source_vloc;
    next_st.oe[nav_io_pkg::OUT_COURSE_HOLD] = st.course_hold || st.nav[nav_io_pkg::NAV_SEQ_SUSPENDED];
    next_st.oe[nav_io_pkg::OUT_TERMINAL] = st.nav[nav_io_pkg::NAV_APPROACH_NAV]
      && st.nav[nav_io_pkg::NAV_WITHIN_TERMINAL] && st.nav[nav_io_pkg::NAV_SCALE_LE_1NM];
    next_st.oe[nav_io_pkg::OUT_APPROACH] = st.nav[nav_io_pkg::NAV_APPROACH_NAV]
      && st.nav[nav_io_pkg::NAV_APPROACH_ACTIVE];
    next_st.oe[nav_io_pkg::OUT_INTEGRITY] = st.nav[nav_io_pkg::NAV_INTEGRITY_FAULT];
    next_st.oe[nav_io_pkg::OUT_APPR_GAIN] = gain;
    next_st.oe[nav_io_pkg::OUT_GUIDANCE_SEL] = !st.source_vloc && !gain;
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign HRDATA = st.hrdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  // Sink drivers pull low only when enabled
  assign DISC_OUT_N = '0;
  assign DISC_OE = st.oe;
  assign TIME_MARK_OUT = st.mark;

  // Helper: length of the current time mark pulse
  logic [MW:0] mark_len;
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      mark_len <= '0;
    end
    else
    begin
      mark_len <= st.mark ? mark_len + (MW+1)'(1) : '0;
    end
  end

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  a_source_toggle: assert property (sw_fall[nav_io_pkg::SW_SOURCE] && !$past(sw_fall[nav_io_pkg::SW_SOURCE])
    |=> st.source_vloc != $past(st.source_vloc))
    else $error("source did not swap on toggle input");
  a_hold_toggle: assert property (sw_fall[nav_io_pkg::SW_COURSE_HOLD]
    |=> ##1 DISC_OE[nav_io_pkg::OUT_COURSE_HOLD] == (st.course_hold || $past(st.nav[nav_io_pkg::NAV_SEQ_SUSPENDED])))
    else $error("course-hold lamp not following the toggled mode");
  a_guidance_gain: assert property (DISC_OE[nav_io_pkg::OUT_GUIDANCE_SEL] |-> !DISC_OE[nav_io_pkg::OUT_APPR_GAIN])
    else $error("guidance select active with approach gain");
  a_source_lamps: assert property (!(DISC_OE[nav_io_pkg::OUT_VOR_LOC] && DISC_OE[nav_io_pkg::OUT_SATNAV]))
    else $error("both source lamps lit");
  a_turn_steady: assert property (st.nav[nav_io_pkg::NAV_IN_TURN][*2] |=> DISC_OE[nav_io_pkg::OUT_WAYPOINT])
    else $error("waypoint lamp dark during turn");
  a_integrity_lamp: assert property ($rose(st.nav[nav_io_pkg::NAV_INTEGRITY_FAULT])
    |=> DISC_OE[nav_io_pkg::OUT_INTEGRITY])
    else $error("integrity lamp late");
  a_alarm_start: assert property ($rose(st.nav[nav_io_pkg::NAV_IN_ALARM_RADIUS]) && st.nav[nav_io_pkg::NAV_ALARM_SET]
    |=> st.alarm_cnt == AW'(ALARM_CYCLES))
    else $error("arrival alarm flash not started");
  a_mark_width: assert property ($fell(TIME_MARK_OUT) |-> mark_len == (MW+1)'(MARK_CYCLES))
    else $error("time mark width wrong");
  a_preset_step: assert property (sw_fall[nav_io_pkg::SW_PRESET]
    |=> st.standby == $past(st.preset[st.preset_idx]))
    else $error("standby frequency not loaded from preset");
  a_sink_low: assert property (DISC_OUT_N == '0)
    else $error("sink output driven high");
  a_strap_once: assert property (st.strap_taken |=> st.sim_mode == $past(st.sim_mode))
    else $error("simulation mode changed after power-up");

  c_source_swap: cover property (sw_fall[nav_io_pkg::SW_SOURCE] ##1 st.source_vloc);
  c_time_mark: cover property ($rose(TIME_MARK_OUT));
  c_alarm_flash: cover property ($rose(st.alarm_cnt != '0));
  c_preset_step: cover property (sw_fall[nav_io_pkg::SW_PRESET]);

endmodule : nav_discrete_annunciator_io

`default_nettype wire

/* rtl/nav_io_pkg.sv */
// Constants shared by the navigation discrete annunciator and switch logic.
// Assumes a single 40 MHz system clock; every timing count derives from it.
`default_nettype none

package nav_io_pkg;

  // Clock rate and timing figures
  localparam int CLK_KHZ = 40_000;
  localparam int T_DEBOUNCE_MS = 10;
  localparam int T_BLINK_HALF_MS = 250;
  localparam int T_SECOND_MS = 1000;
  localparam int T_MARK_MS = 1;
  localparam int T_ALARM_S = 10;
  localparam int DEBOUNCE_CYCLES = CLK_KHZ * T_DEBOUNCE_MS;
  localparam int BLINK_HALF_CYCLES = CLK_KHZ * T_BLINK_HALF_MS;
  localparam int SECOND_CYCLES = CLK_KHZ * T_SECOND_MS;
  localparam int MARK_CYCLES = CLK_KHZ * T_MARK_MS;
  localparam int ALARM_CYCLES = CLK_KHZ * 1000 * T_ALARM_S;

  // Register byte offsets
  localparam logic [7:0] REG_NAV_STATE = 8'h00;
  localparam logic [7:0] REG_EVENT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_STANDBY = 8'h0C;
  localparam logic [7:0] REG_PRESET_BASE = 8'h10;

  // Navigation state register fields
  localparam int NAV_W = 16;
  localparam logic [NAV_W-1:0] NAV_RESET = 16'h0000;
  localparam int NAV_MSG_ACTIVE = 0;
  localparam int NAV_TURN_PENDING = 1;
  localparam int NAV_IN_TURN = 2;
  localparam int NAV_ALARM_SET = 3;
  localparam int NAV_IN_ALARM_RADIUS = 4;
  localparam int NAV_NEAR_ARRIVAL = 5;
  localparam int NAV_APPROACH_NAV = 6;
  localparam int NAV_WITHIN_TERMINAL = 7;
  localparam int NAV_SCALE_LE_1NM = 8;
  localparam int NAV_APPROACH_ACTIVE = 9;
  localparam int NAV_INTEGRITY_FAULT = 10;
  localparam int NAV_SATNAV_APPR_MODE = 11;
  localparam int NAV_SCALE_0P3 = 12;
  localparam int NAV_ILS_TUNED = 13;
  localparam int NAV_SINGLE_INDICATOR = 14;
  localparam int NAV_SEQ_SUSPENDED = 15;

  // Event register bits, write one to act
  localparam int EV_MSG_NEW = 0;
  localparam int EV_KEY_SOURCE = 1;
  localparam int EV_KEY_COURSE_HOLD = 2;
  localparam int EV_MSG_ACK = 3;

  // Status register fields
  localparam int ST_SOURCE_VLOC = 0;
  localparam int ST_COURSE_HOLD = 1;
  localparam int ST_SIM_MODE = 2;
  localparam int ST_MSG_FLASH = 3;
  localparam int ST_ALARM_FLASH = 4;
  localparam int ST_TIME_MARK = 5;
  localparam int ST_IDX_LSB = 8;
  localparam int ST_OE_LSB = 16;

  // Switch input indexes
  localparam int NUM_SW = 4;
  localparam int SW_SOURCE = 0;
  localparam int SW_COURSE_HOLD = 1;
  localparam int SW_PRESET = 2;
  localparam int SW_STRAP = 3;

  // Sinking output indexes
  localparam int NUM_OUT = 10;
  localparam int OUT_MSG = 0;
  localparam int OUT_WAYPOINT = 1;
  localparam int OUT_VOR_LOC = 2;
  localparam int OUT_SATNAV = 3;
  localparam int OUT_COURSE_HOLD = 4;
  localparam int OUT_TERMINAL = 5;
  localparam int OUT_APPROACH = 6;
  localparam int OUT_INTEGRITY = 7;
  localparam int OUT_APPR_GAIN = 8;
  localparam int OUT_GUIDANCE_SEL = 9;

  localparam int FREQ_W = 16;
  localparam int NUM_PRESETS = 4;

endpackage : nav_io_pkg

`default_nettype wire

/* rtl/switch_debounce.sv */
// Debouncer for one grounded switch input with a falling-edge pulse.
// Assumes the pin is asynchronous to clk and active low.
`default_nettype none

module switch_debounce #(
  parameter int DEBOUNCE_CYCLES = nav_io_pkg::DEBOUNCE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Pin and result
  input wire logic pin_n,
  output logic level_n,
  output logic fall,
  output logic ready
);

  localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [CW-1:0] cnt;
    logic level_n;
    logic fall;
    logic ready;
  } deb_t;

  deb_t st;
  deb_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.s1 = pin_n;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.fall = 1'b0;
    if (st.s2 != st.s3)
    begin
      next_st.cnt = '0;
    end
    else if (st.cnt == CW'(DEBOUNCE_CYCLES - 1))
    begin
      // Stable long enough; a held low never repeats the pulse
      next_st.level_n = st.s3;
      next_st.fall = st.level_n & ~st.s3;
      next_st.ready = 1'b1;
    end
    else
    begin
      next_st.cnt = st.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, cnt: '0, level_n: 1'b1, fall: 1'b0, ready: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign level_n = st.level_n;
  assign fall = st.fall;
  assign ready = st.ready;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_fall_single: assert property (fall |=> !fall)
    else $error("switch pulse repeated");
  a_fall_level: assert property (fall |-> !level_n && $past(level_n))
    else $error("switch pulse without a new low level");

endmodule : switch_debounce

`default_nettype wire

/* tb/panel_model.sv */
// Far side: grounded panel switches, pulled-up sinking lamp wires, time ref.
// Assumes switch wires idle at supply level and lamps read through pull-ups.
`default_nettype none

module panel_model
(
  // Clock
  input wire logic clk,
  // Switch and reference wires
  output logic [3:0] sw_n,
  output logic time_ref,
  // Sinking outputs and resolved lamp state
  input wire logic [nav_io_pkg::NUM_OUT-1:0] disc_out_n,
  input wire logic [nav_io_pkg::NUM_OUT-1:0] disc_oe,
  output logic [nav_io_pkg::NUM_OUT-1:0] lit
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [nav_io_pkg::NUM_OUT-1:0] wire_lvl;

  initial
  begin
    sw_n = 4'hf;
    time_ref = 1'b0;
  end

  // Released driver floats to the pull-up, so only a sink lights the lamp
  assign wire_lvl = ~(disc_oe & ~disc_out_n);
  assign lit = ~wire_lvl;

  // Momentary ground, then a long release before the next press
  task automatic press(input int idx, input int hold);
    @(posedge clk);
    sw_n[idx] <= 1'b0;
    repeat (hold) @(posedge clk);
    sw_n[idx] <= 1'b1;
    repeat (24) @(posedge clk);
  endtask : press

  // Reference second edge, held a few cycles so the synchroniser sees it
  task automatic ref_pulse;
    @(posedge clk);
    time_ref <= 1'b1;
    repeat (4) @(posedge clk);
    time_ref <= 1'b0;
  endtask : ref_pulse

  // Bench-only strap; never tied in an installation
  task automatic tie_strap;
    sw_n[nav_io_pkg::SW_STRAP] <= 1'b0;
  endtask : tie_strap
endmodule : panel_model

`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench: AHB-Lite master tasks, switch presses, lamp sampling.
// Assumes shortened timing parameters and a zero-wait-state slave.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, arst_n, hsel, hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize, wsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic hreadyout, hresp, mark;
  logic [3:0] sw_n;
  logic tref;
  logic [9:0] dout_n, doe, lit;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int n, m, i;
  logic [15:0] nav [12] = '{16'h4000, 16'h0400, 16'h01C0, 16'h0180, 16'h0240, 16'h0800,
    16'h1000, 16'h2000, 16'h8000, 16'h0004, 16'h0001, 16'h0000};
  logic [9:0] exp_lit [12] = '{10'h208, 10'h280, 10'h220, 10'h200, 10'h240, 10'h100,
    10'h100, 10'h200, 10'h210, 10'h202, 10'h201, 10'h200};
  logic [15:0] wpt [4] = '{16'h0002, 16'h0006, 16'h0020, 16'h0008};
  int wpt_n [4] = '{16, 32, 16, 0};

  nav_discrete_annunciator_io #(.DEBOUNCE_CYCLES(8), .BLINK_HALF_CYCLES(8), .SECOND_CYCLES(200),
    .MARK_CYCLES(10), .ALARM_CYCLES(50), .NUM_PRESETS(4)) i_dut (.SYS_CLK(clk), .ARST_N(arst_n),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .NAV_SOURCE_TOGGLE_IN_N(sw_n[0]), .COURSE_HOLD_TOGGLE_IN_N(sw_n[1]), .PRESET_STEP_IN_N(sw_n[2]),
    .SIM_STRAP_IN_N(sw_n[3]), .TIME_REF_IN(tref), .DISC_OUT_N(dout_n), .DISC_OE(doe),
    .TIME_MARK_OUT(mark));

  panel_model i_panel (.clk(clk), .sw_n(sw_n), .time_ref(tref), .disc_out_n(dout_n),
    .disc_oe(doe), .lit(lit));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      num_errors++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  // Address phase held until ready, then data phase held until ready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    hsize <= wsize;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    tick(3);
  endtask : bus

  task automatic ones(input int b);
    n = 0;
    repeat (32)
    begin
      tick(1);
      n += int'(lit[b]);
    end
  endtask : ones

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  initial
  begin
    arst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'b010;
    wsize = 3'b010;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    tick(2);
    arst_n <= 1'b1;
    tick(30);
    bus(1'b0, 8'h00, 32'h0000_0000);
    check(q, 32'h0000_0000);
    check(hresp, 1'b0);
    bus(1'b0, 8'h08, 32'h0000_0000);
    check(q & 32'h0000_0007, 32'h0000_0000);
    bus(1'b0, 8'h40, 32'h0000_0000);
    check(q, 32'h0000_0000);
    for (i = 0; i < 12; i++)
    begin
      bus(1'b1, 8'h00, {16'h0000, nav[i]});
      check(lit, exp_lit[i]);
    end
    $display("test lamps done");
    i_panel.press(0, 40);
    bus(1'b0, 8'h08, 32'h0000_0000);
    check(q[0], 1'b1);
    bus(1'b1, 8'h00, 32'h0000_6000);
    check(lit, 10'h104);
    bus(1'b1, 8'h00, 32'h0000_4000);
    check(lit, 10'h004);
    i_panel.press(1, 3);
    check(lit[4], 1'b0);
    i_panel.press(1, 12);
    check(lit[4], 1'b1);
    bus(1'b1, 8'h04, 32'h0000_0006);
    bus(1'b0, 8'h08, 32'h0000_0000);
    check(q[1:0], 2'b00);
    $display("test switches done");
    bus(1'b1, 8'h10, 32'h0000_1234);
    bus(1'b1, 8'h14, 32'h0000_5678);
    i_panel.press(2, 12);
    bus(1'b0, 8'h0C, 32'h0000_0000);
    check(q, 32'h0000_1234);
    i_panel.press(2, 12);
    bus(1'b0, 8'h0C, 32'h0000_0000);
    check(q, 32'h0000_5678);
    bus(1'b0, 8'h08, 32'h0000_0000);
    check(q[9:8], 2'b10);
    wsize = 3'b001;
    bus(1'b1, 8'h18, 32'h0000_abcd);
    wsize = 3'b010;
    bus(1'b0, 8'h18, 32'h0000_0000);
    check(q, 32'h0000_0000);
    $display("test presets done");
    bus(1'b1, 8'h00, 32'h0000_0001);
    bus(1'b1, 8'h04, 32'h0000_0001);
    ones(0);
    check(n, 16);
    bus(1'b1, 8'h04, 32'h0000_0008);
    ones(0);
    check(n, 32);
    for (i = 0; i < 4; i++)
    begin
      bus(1'b1, 8'h00, {16'h0000, wpt[i]});
      ones(1);
      check(n, wpt_n[i]);
    end
    bus(1'b1, 8'h00, 32'h0000_0018);
    ones(1);
    check(n, 16);
    tick(30);
    ones(1);
    check(n, 0);
    $display("test flashing done");
    n = 0;
    while (mark !== 1'b1) tick(1);
    while (mark === 1'b1)
    begin
      tick(1);
      n++;
    end
    check(n, 10);
    m = n;
    while (mark !== 1'b1)
    begin
      tick(1);
      m++;
    end
    check(m, 200);
    tick(50);
    i_panel.ref_pulse();
    tick(0);
    check(mark, 1'b1);
    m = 0;
    while (mark === 1'b1)
    begin
      tick(1);
      m++;
    end
    while (mark !== 1'b1)
    begin
      tick(1);
      m++;
    end
    check(m, 199);
    $display("test time mark done");
    i_panel.tie_strap();
    arst_n <= 1'b0;
    tick(2);
    arst_n <= 1'b1;
    tick(30);
    bus(1'b0, 8'h08, 32'h0000_0000);
    check(q[2], 1'b1);
    $display("test strap done");
    finish_test();
  end
endmodule : testbench

`default_nettype wire
